// file: hdl/udr_consts.svh
// Constants of the UART DMA ready block: write decode, FIFO control field
// positions, reset values and occupancy figures.
// Assumes it is included by bare name from the package and design files.
`ifndef UDR_CONSTS_SVH
`define UDR_CONSTS_SVH

// Host write port widths
`define UDR_ADDR_W          3
`define UDR_DATA_W          8

// Occupancy counts cover 0 .. 64 characters
`define UDR_CNT_W           7
`define UDR_CNT_EMPTY       7'h00
`define UDR_FIFO_DEPTH      7'h40

// FIFO control register location and fields
`define UDR_FIFO_CTRL_ADDR  3'h2
`define UDR_FIFO_EN_BIT     0
`define UDR_DMA_SEL_BIT     3

// Reset values
`define UDR_FIFO_EN_RST     1'b0
`define UDR_DMA_SEL_RST     1'b0
`define UDR_REQ_IDLE        1'b1
`define UDR_LINE_MARK       1'b1

`endif

// file: hdl/udr_dma_ready.sv
// UART DMA ready signalling: FIFO control bits, receive and transmit DMA
// request outputs, and the serial output held at mark during reset.
// Assumes FIFO occupancy, trigger and time-out come from the UART core,
// all synchronous to i_mclk.
`timescale 1ns/1ps

`include "udr_consts.svh"

module udr_dma_ready
  import udr_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_srst,
  input  wire logic                    i_chip_sel,
  input  wire logic                    i_wr_strobe,
  input  wire logic                    i_wr_strobe_n,
  input  wire logic [`UDR_ADDR_W-1:0]  i_addr,
  input  wire logic [`UDR_DATA_W-1:0]  i_wdata,
  input  wire logic [`UDR_CNT_W-1:0]   i_rx_count,
  input  wire logic                    i_rx_trigger_hit,
  input  wire logic                    i_rx_timeout,
  input  wire logic [`UDR_CNT_W-1:0]   i_tx_count,
  input  wire logic                    i_tx_serial,
  output logic                         o_receive_dma_request_n,
  output logic                         o_transmit_dma_request_n,
  output logic                         o_serial_out,
  output logic                         o_fifo_enable_bit,
  output logic                         o_dma_mode_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic cnt_empty(input logic [`UDR_CNT_W-1:0] cnt);
    cnt_empty = (cnt == `UDR_CNT_EMPTY);
  endfunction

  function automatic logic cnt_has_room(input logic [`UDR_CNT_W-1:0] cnt);
    cnt_has_room = (cnt < `UDR_FIFO_DEPTH);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host write decode

  wire           wr_pulse;
  wire           fcr_wr;
  logic          fifo_en_q;
  logic          fifo_en_d;
  logic          dma_sel_q;
  logic          dma_sel_d;

  udr_write_strobe u_write_strobe (
    .i_mclk        (i_mclk),
    .i_srst        (i_srst),
    .i_chip_sel    (i_chip_sel),
    .i_wr_strobe   (i_wr_strobe),
    .i_wr_strobe_n (i_wr_strobe_n),
    .o_wr_pulse    (wr_pulse)
  );

  // Only the FIFO control location is held here; other writes are ignored
  assign fcr_wr    = wr_pulse & (i_addr == `UDR_FIFO_CTRL_ADDR);
  assign fifo_en_d = fcr_wr ? i_wdata[`UDR_FIFO_EN_BIT] : fifo_en_q;
  assign dma_sel_d = fcr_wr ? i_wdata[`UDR_DMA_SEL_BIT] : dma_sel_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      fifo_en_q <= `UDR_FIFO_EN_RST;
      dma_sel_q <= `UDR_DMA_SEL_RST;
    end else begin
      fifo_en_q <= fifo_en_d;
      dma_sel_q <= dma_sel_d;
    end
  end

  assign o_fifo_enable_bit = fifo_en_q;
  assign o_dma_mode_select = dma_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Effective mode

  udr_dma_mode_t mode;

  // Select bit is kept but ignored while the FIFOs are off
  assign mode = (fifo_en_q & dma_sel_q) ? UDR_MODE_MULTI : UDR_MODE_SINGLE;

  ////////////////////////////////////////////////////////////////////////////
  // Receive request

  wire           rx_empty;
  wire           rx_start;
  udr_rx_state_t rx_state_q;
  udr_rx_state_t rx_state_d;
  logic          rx_req_n_q;
  logic          rx_req_n_d;

  assign rx_empty = cnt_empty(i_rx_count);
  // A time-out with nothing left to move would raise a request nobody can serve
  assign rx_start = (i_rx_trigger_hit | i_rx_timeout) & ~rx_empty;

  always_comb begin
    rx_state_d = rx_state_q;
    if (mode != UDR_MODE_MULTI) begin
      rx_state_d = UDR_RX_IDLE;
    end else begin
      case (rx_state_q)
        UDR_RX_IDLE: begin
          if (rx_start) begin
            rx_state_d = UDR_RX_BURST;
          end
        end
        UDR_RX_BURST: begin
          if (rx_empty) begin
            rx_state_d = UDR_RX_IDLE;
          end
        end
        default: begin
          rx_state_d = UDR_RX_IDLE;
        end
      endcase
    end
  end

  // Mode 0 follows occupancy directly, one request per character
  assign rx_req_n_d = (mode == UDR_MODE_MULTI) ? (rx_state_d != UDR_RX_BURST) : rx_empty;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_state_q <= UDR_RX_IDLE;
      rx_req_n_q <= `UDR_REQ_IDLE;
    end else begin
      rx_state_q <= rx_state_d;
      rx_req_n_q <= rx_req_n_d;
    end
  end

  assign o_receive_dma_request_n = rx_req_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit request

  logic tx_req_n_q;
  logic tx_req_n_d;

  // Mode 0 asks only once the holding stage is empty; mode 1 until full
  assign tx_req_n_d = (mode == UDR_MODE_MULTI) ? ~cnt_has_room(i_tx_count)
                                               : ~cnt_empty(i_tx_count);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_req_n_q <= `UDR_REQ_IDLE;
    end else begin
      tx_req_n_q <= tx_req_n_d;
    end
  end

  assign o_transmit_dma_request_n = tx_req_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial output

  logic serial_q;

  // Registered so the line is at mark from the first clock edge of reset, not only after it
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      serial_q <= `UDR_LINE_MARK;
    end else begin
      serial_q <= i_tx_serial;
    end
  end

  assign o_serial_out = serial_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_serial_mark_reset: assert property (
    @(posedge i_mclk) disable iff (1'b0)
    i_srst |=> o_serial_out)
    else $error("Serial output not at mark after reset");

  a_fifo_enable_write: assert property (
    fcr_wr |=> (o_fifo_enable_bit == $past(i_wdata[`UDR_FIFO_EN_BIT])))
    else $error("FIFO enable not taken from write");

  a_mode_select_write: assert property (
    fcr_wr |=> (o_dma_mode_select == $past(i_wdata[`UDR_DMA_SEL_BIT])))
    else $error("DMA mode select not taken from write");

  a_strobe_either: assert property (
    (i_chip_sel && (i_wr_strobe ^ !i_wr_strobe_n) && i_addr == `UDR_FIFO_CTRL_ADDR
     && !$past(i_chip_sel)) |=> (o_fifo_enable_bit == $past(i_wdata[`UDR_FIFO_EN_BIT])))
    else $error("Write by one strobe not accepted");

  a_legacy_rx_single: assert property (
    (!o_fifo_enable_bit && !fcr_wr && o_dma_mode_select && i_rx_trigger_hit
     && cnt_empty(i_rx_count)) |=> o_receive_dma_request_n)
    else $error("Non-FIFO mode used multi-transfer signalling");

  a_rx_single_low: assert property (
    (mode == UDR_MODE_SINGLE && !fcr_wr && !cnt_empty(i_rx_count))
    |=> !o_receive_dma_request_n)
    else $error("Mode 0 receive request not active with data");

  a_rx_single_high: assert property (
    (mode == UDR_MODE_SINGLE && !fcr_wr && cnt_empty(i_rx_count))
    |=> o_receive_dma_request_n)
    else $error("Mode 0 receive request active while empty");

  a_rx_multi_start: assert property (
    (mode == UDR_MODE_MULTI && !fcr_wr && (i_rx_trigger_hit || i_rx_timeout)
     && !cnt_empty(i_rx_count)) |=> !o_receive_dma_request_n)
    else $error("Mode 1 receive request missed trigger or time-out");

  a_rx_multi_hold: assert property (
    (mode == UDR_MODE_MULTI && !fcr_wr && !o_receive_dma_request_n
     && !cnt_empty(i_rx_count)) |=> !o_receive_dma_request_n)
    else $error("Mode 1 receive request dropped before empty");

  a_rx_multi_wait: assert property (
    (mode == UDR_MODE_MULTI && !fcr_wr && o_receive_dma_request_n
     && !i_rx_trigger_hit && !i_rx_timeout) |=> o_receive_dma_request_n)
    else $error("Mode 1 receive request without trigger");

  a_rx_multi_release: assert property (
    (mode == UDR_MODE_MULTI && cnt_empty(i_rx_count)) |=> o_receive_dma_request_n)
    else $error("Mode 1 receive request kept after empty");

  a_tx_multi_full: assert property (
    (mode == UDR_MODE_MULTI && !fcr_wr)
    |=> (o_transmit_dma_request_n == ($past(i_tx_count) >= `UDR_FIFO_DEPTH)))
    else $error("Mode 1 transmit request wrong against fill level");

  a_tx_single_empty: assert property (
    (mode == UDR_MODE_SINGLE && !fcr_wr)
    |=> (o_transmit_dma_request_n == ($past(i_tx_count) != `UDR_CNT_EMPTY)))
    else $error("Mode 0 transmit request wrong against holding state");

  // Legacy mode must ignore the select bit and every trigger
  a_legacy_rx_data: assert property (
    (!o_fifo_enable_bit && !fcr_wr && !cnt_empty(i_rx_count))
    |=> !o_receive_dma_request_n)
    else $error("Non-FIFO receive request not active with data");

  a_legacy_tx_hold: assert property (
    (!o_fifo_enable_bit && !fcr_wr)
    |=> (o_transmit_dma_request_n == ($past(i_tx_count) != `UDR_CNT_EMPTY)))
    else $error("Non-FIFO transmit request not single-transfer");

  a_legacy_no_burst: assert property (
    (!o_fifo_enable_bit && !fcr_wr) |=> (rx_state_q == UDR_RX_IDLE))
    else $error("Receive burst state held in non-FIFO mode");

  a_ctrl_bits_hold: assert property (
    !fcr_wr |=> ($stable(o_fifo_enable_bit) && $stable(o_dma_mode_select)))
    else $error("FIFO control bits changed without a write");

  // Requests idle through reset so a DMA controller never sees a stale ask
  a_rx_reset_idle: assert property (
    @(posedge i_mclk) disable iff (1'b0)
    i_srst |=> o_receive_dma_request_n)
    else $error("Receive request active after reset");

  a_tx_reset_idle: assert property (
    @(posedge i_mclk) disable iff (1'b0)
    i_srst |=> o_transmit_dma_request_n)
    else $error("Transmit request active after reset");

  c_rx_burst: cover property (
    (mode == UDR_MODE_MULTI && rx_start) ##1 !o_receive_dma_request_n [*3]
    ##1 o_receive_dma_request_n);

  c_tx_fill: cover property (
    (mode == UDR_MODE_MULTI && !o_transmit_dma_request_n) ##[1:200] o_transmit_dma_request_n);

  c_legacy_rx: cover property (
    (mode == UDR_MODE_SINGLE && !o_fifo_enable_bit) ##1 !o_receive_dma_request_n);

  c_low_strobe_write: cover property (fcr_wr && !i_wr_strobe_n && !i_wr_strobe);

  c_rx_timeout: cover property (
    (mode == UDR_MODE_MULTI && i_rx_timeout && rx_start)
    ##1 !o_receive_dma_request_n);

endmodule

// file: hdl/udr_pkg.sv
// Types of the UART DMA ready block.
// Assumes udr_consts.svh sits on the include path.
`include "udr_consts.svh"

package udr_pkg;

  // Receive request sequencing for multi-transfer signalling
  typedef enum logic [1:0] {
    UDR_RX_IDLE  = 2'b00,
    UDR_RX_BURST = 2'b01
  } udr_rx_state_t;

  // Effective DMA signalling mode
  typedef enum logic {
    UDR_MODE_SINGLE = 1'b0,
    UDR_MODE_MULTI  = 1'b1
  } udr_dma_mode_t;

endpackage

// file: hdl/udr_write_strobe.sv
// Write strobe combiner: merges the active-high and active-low write inputs
// under chip select into one pulse per host write.
// Assumes all inputs are synchronous to i_mclk.
`timescale 1ns/1ps

module udr_write_strobe
  import udr_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_srst,
  input  wire logic i_chip_sel,
  input  wire logic i_wr_strobe,
  input  wire logic i_wr_strobe_n,
  output logic      o_wr_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode

  wire wr_active;
  logic wr_active_q;

  // Either strobe may carry the write; the spare one idles inactive
  assign wr_active  = i_chip_sel & (i_wr_strobe | ~i_wr_strobe_n);
  // One pulse per strobe so a long host cycle writes only once
  assign o_wr_pulse = wr_active & ~wr_active_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wr_active_q <= 1'b0;
    end else begin
      wr_active_q <= wr_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_pulse_needs_select: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    o_wr_pulse |-> (i_chip_sel && (i_wr_strobe || !i_wr_strobe_n)))
    else $error("Write pulse without select and strobe");

  a_pulse_single: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    o_wr_pulse |=> !o_wr_pulse)
    else $error("Write pulse longer than one cycle");

endmodule

// file: test/tb_udr_dma_ready.sv
// Self-checking bench for the DMA ready block.
// Assumes udr_dma_model stands in for the UART core and the DMA controller.
`timescale 1ns/1ps
`include "udr_consts.svh"

module tb_udr_dma_ready;
  import udr_pkg::*;
  logic i_mclk = 0, i_srst = 1, cs = 0, wr = 0, wr_n = 1, trig = 0, tmo = 0, txs = 0;
  logic set_v = 0, en = 0, rq_n, tq_n, sout, fen, msel;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [6:0] rx_set = 7'h00, tx_set = 7'h00, rx_cnt, tx_cnt;
  int error_cnt = 0, cmp_count = 0, cyc = 0, i;

  always #10 i_mclk = ~i_mclk;

  udr_dma_ready u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_chip_sel(cs), .i_wr_strobe(wr),
    .i_wr_strobe_n(wr_n), .i_addr(addr), .i_wdata(wdata), .i_rx_count(rx_cnt),
    .i_rx_trigger_hit(trig), .i_rx_timeout(tmo), .i_tx_count(tx_cnt), .i_tx_serial(txs),
    .o_receive_dma_request_n(rq_n), .o_transmit_dma_request_n(tq_n), .o_serial_out(sout),
    .o_fifo_enable_bit(fen), .o_dma_mode_select(msel));

  udr_dma_model u_far (.i_mclk(i_mclk), .i_srst(i_srst), .i_en(en), .i_set(set_v),
    .i_rx_set(rx_set), .i_tx_set(tx_set), .i_rx_req_n(rq_n), .i_tx_req_n(tq_n),
    .o_rx_count(rx_cnt), .o_tx_count(tx_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ceiling well above the hundred or so cycles the scenarios need
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Inputs move 2 ns after the edge so the design never races the bench
  task automatic step();
    @(posedge i_mclk);
    #2;
  endtask

  // Only one strobe moves; the other idles inactive
  task automatic wr_reg(input logic c, input logic hi, input logic [2:0] a,
                        input logic [7:0] d);
    cs = c;
    wr = hi;
    wr_n = hi;
    addr = a;
    wdata = d;
    step();
    cs = 0;
    wr = 0;
    wr_n = 1;
    step();
  endtask

  task automatic ld(input logic [6:0] r, input logic [6:0] t);
    rx_set = r;
    tx_set = t;
    set_v = 1;
    step();
    set_v = 0;
    step();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (6) step();
    chk("serial in reset", sout, 1'b1);
    chk("rx req in reset", rq_n, 1'b1);
    chk("tx req in reset", tq_n, 1'b1);
    chk("fifo en reset", fen, 1'b0);
    chk("mode sel reset", msel, 1'b0);
    i_srst = 0;
    step();
    chk("serial follows", sout, 1'b0);
    txs = 1;
    step();
    chk("serial high", sout, 1'b1);
    txs = 0;
    step();
  endtask

  task automatic t_write();
    wr_reg(1, 0, 3'h2, 8'h09);
    chk("en via low strobe", fen, 1'b1);
    chk("sel via low strobe", msel, 1'b1);
    wr_reg(1, 1, 3'h2, 8'h00);
    chk("clear via high strobe", fen, 1'b0);
    wr_reg(1, 1, 3'h1, 8'h09);
    chk("other address", fen, 1'b0);
    wr_reg(0, 0, 3'h2, 8'h09);
    chk("not selected", fen, 1'b0);
  endtask

  // Non-FIFO with select set, and FIFO with select clear: both single transfer
  task automatic t_mode0();
    logic [7:0] cfg [2] = '{8'h08, 8'h01};
    for (i = 0; i < 2; i++) begin
      wr_reg(1, 0, 3'h2, cfg[i]);
      ld(7'h03, 7'h00);
      chk("mode0 rx data", rq_n, 1'b0);
      chk("mode0 tx empty", tq_n, 1'b0);
      // Trigger is raised too: single-transfer mode must not react to it
      trig = 1;
      ld(7'h00, 7'h01);
      trig = 0;
      chk("mode0 rx empty", rq_n, 1'b1);
      chk("mode0 tx busy", tq_n, 1'b1);
    end
  endtask

  task automatic drain();
    en = 1;
    for (i = 0; i < 20 && rq_n !== 1'b1; i++) begin
      step();
      if (rq_n === 1'b1) chk("high only empty", rx_cnt, 7'h00);
    end
    en = 0;
    chk("drained req", rq_n, 1'b1);
  endtask

  task automatic t_mode1_rx();
    wr_reg(1, 1, 3'h2, 8'h09);
    ld(7'h02, 7'h00);
    chk("mode1 below trigger", rq_n, 1'b1);
    trig = 1;
    step();
    trig = 0;
    chk("mode1 trigger", rq_n, 1'b0);
    step();
    chk("mode1 holds", rq_n, 1'b0);
    drain();
    ld(7'h04, 7'h00);
    tmo = 1;
    step();
    tmo = 0;
    chk("mode1 timeout", rq_n, 1'b0);
    drain();
    trig = 1;
    step();
    trig = 0;
    chk("trigger while empty", rq_n, 1'b1);
  endtask

  task automatic t_mode1_tx();
    ld(7'h00, 7'h3f);
    chk("tx one free", tq_n, 1'b0);
    ld(7'h00, 7'h40);
    chk("tx full", tq_n, 1'b1);
    ld(7'h00, 7'h3a);
    en = 1;
    for (i = 0; i < 20 && tx_cnt !== `UDR_FIFO_DEPTH; i++) step();
    step();
    en = 0;
    chk("filled count", tx_cnt, `UDR_FIFO_DEPTH);
    chk("filled req", tq_n, 1'b1);
  endtask

  // Reset in the middle of a receive burst
  task automatic t_reset_mid();
    ld(7'h05, 7'h00);
    trig = 1;
    step();
    trig = 0;
    chk("burst before reset", rq_n, 1'b0);
    i_srst = 1;
    step();
    chk("serial mark mid reset", sout, 1'b1);
    chk("rx req mid reset", rq_n, 1'b1);
    chk("fifo en mid reset", fen, 1'b0);
    chk("mode sel mid reset", msel, 1'b0);
    i_srst = 0;
    step();
    chk("legacy tx after reset", tq_n, 1'b0);
    chk("rx req after reset", rq_n, 1'b1);
  endtask

  initial begin
    t_reset();
    t_write();
    t_mode0();
    t_mode1_rx();
    t_mode1_tx();
    t_reset_mid();
    summarize();
  end
endmodule

// file: test/udr_dma_model.sv
// Far-side model: UART core occupancy plus a DMA controller that serves requests.
// Assumes the bench loads counts through i_set and gates service with i_en.
`timescale 1ns/1ps
`include "udr_consts.svh"

module udr_dma_model (
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  input  wire logic                  i_en,
  input  wire logic                  i_set,
  input  wire logic [`UDR_CNT_W-1:0] i_rx_set,
  input  wire logic [`UDR_CNT_W-1:0] i_tx_set,
  input  wire logic                  i_rx_req_n,
  input  wire logic                  i_tx_req_n,
  output logic      [`UDR_CNT_W-1:0] o_rx_count,
  output logic      [`UDR_CNT_W-1:0] o_tx_count
);
  // Guards stop over- and underrun, since the requests lag the counts by one cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rx_count <= `UDR_CNT_EMPTY;
      o_tx_count <= `UDR_CNT_EMPTY;
    end else if (i_set) begin
      o_rx_count <= i_rx_set;
      o_tx_count <= i_tx_set;
    end else if (i_en) begin
      if (!i_rx_req_n && o_rx_count != `UDR_CNT_EMPTY) o_rx_count <= o_rx_count - 7'h01;
      if (!i_tx_req_n && o_tx_count < `UDR_FIFO_DEPTH) o_tx_count <= o_tx_count + 7'h01;
    end
  end
endmodule
